// ---- design/fpr_pkg.sv ----
// Package with register map, fuse field layout and reset values for the flash parameter and fuse readout.
//
// Contract
// - Page size code sits in bits 10:8; code n means 32 bytes shifted by n.
// - Flash size code sits in bits 3:0; codes 0-14 map sizes, 15 reserved.
// - Revision in bits 11:0, variant in 19:16, other bits zero, no behaviour.
// - A fuse bit reads 0 when programmed and 1 when erased.
// - Upper fuse word serves only beyond 32 fuses; unused here.
// - Exactly 32 fuses, all in the lower word, fuse k at bit k.
// - User page values reach consumers only after the next chip reset.
// - Debug chip erase returns every fuse to the erased state.
// - Right after chip erase the lower fuse word reads all ones.
// - Brown-out enable bits 31:30: 01 with reset, 10 without, else off.
// - Hysteresis bit 29 enables hysteresis when one.
// - Trigger level bits 28:23; all zero is lowest, never triggers.
// - Shipped lower fuse word reads 0xE07FFFFF.
// - Boot guard bits 19:17 all ones leave boot protection off.
// - External fetch lock bit 16 at one leaves fetch unlocked.
// - Region lock bits 15:0 all ones leave every region unlocked.
// - Watchdog autostart bit 0 of first user word at zero starts watchdog.
// - Watchdog autostart bit at one, erased, leaves watchdog stopped.
package fpr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_GEOMETRY   = 8'h0C;
  localparam logic [7:0] OFS_REVISION   = 8'h10;
  localparam logic [7:0] OFS_FUSE_UPPER = 8'h14;
  localparam logic [7:0] OFS_FUSE_LOWER = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int PAGE_SIZE_LSB   = 8;
  localparam int FLASH_SIZE_LSB  = 0;
  localparam int VARIANT_LSB     = 16;
  localparam int BOD_EN_LSB      = 30;
  localparam int BOD_HYST_POS    = 29;
  localparam int BOD_LEVEL_LSB   = 23;
  localparam int USER_GUARD_POS  = 22;
  localparam int BOOT_GUARD_LSB  = 17;
  localparam int FETCH_LOCK_POS  = 16;
  localparam int REGION_LOCK_LSB = 0;
  localparam int WDT_AUTO_POS    = 0;

  // ==========================================================================
  // Values
  localparam logic [31:0] FUSE_SHIPPED  = 32'hE07FFFFF;
  localparam logic [31:0] FUSE_ERASED   = 32'hFFFFFFFF;
  localparam logic [31:0] USER_ERASED   = 32'hFFFFFFFF;
  localparam logic [31:0] UPPER_UNUSED  = 32'h00000000;
  localparam logic [2:0]  PAGE_CODE_DEF = 3'h4;
  localparam logic [3:0]  FLASH_CODE_DEF = 4'h9;
  localparam logic [3:0]  FLASH_CODE_RSVD = 4'hF;
  localparam logic [1:0]  BOD_EN_RESET  = 2'h1;
  localparam logic [1:0]  BOD_EN_NORST  = 2'h2;
  // Edges after reset release during which the fuse and user words reload.
  localparam logic [1:0]  LOAD_CYCLES   = 2'h3;

  // Decoded brown-out configuration handed to the detector.
  typedef struct packed {
    logic       enable;
    logic       reset_enable;
    logic       hysteresis;
    logic [5:0] level;
    logic       level_inert;
  } fpr_bod_cfg_s;

  // Decoded flash protection configuration.
  typedef struct packed {
    logic        user_page_guard;
    logic [2:0]  boot_guard_field;
    logic        boot_guard_off;
    logic        fetch_unlocked;
    logic [15:0] region_lock;
    logic        all_regions_open;
  } fpr_prot_cfg_s;

endpackage

// ---- design/fpr_readout.sv ----
// Flash parameter, revision and general purpose fuse readout register bank.
`timescale 1ns/1ps

module fpr_readout #(
  parameter logic [2:0]  PAGE_SIZE_CODE  = fpr_pkg::PAGE_CODE_DEF,
  parameter logic [3:0]  FLASH_SIZE_CODE = fpr_pkg::FLASH_CODE_DEF,
  parameter logic [11:0] REVISION        = 12'h001, // Arbitrary value.
  parameter logic [3:0]  VARIANT         = 4'h0     // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Register port.
  input  wire logic [7:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic [31:0]                rdata,
  // Fuse array and user page contents, from the nonvolatile store.
  input  wire logic [31:0]           fuse_array,
  input  wire logic [31:0]           user_word0,
  // Debug chip erase, a level held while the erase runs.
  input  wire logic                  chip_erase,
  // Decoded configuration for other modules.
  output fpr_pkg::fpr_bod_cfg_s      bod_cfg,
  output fpr_pkg::fpr_prot_cfg_s     prot_cfg,
  output logic                       watchdog_autostart
);

  // ==========================================================================
  // Input synchronisers
  logic [31:0] fuse_meta;
  logic [31:0] fuse_sync;
  logic [31:0] user_meta;
  logic [31:0] user_sync;
  logic        erase_meta;
  logic        erase_sync;

  // Two stages on the fuse, user page and erase inputs; only the second stage is used.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fuse_meta  <= fpr_pkg::FUSE_SHIPPED;
      fuse_sync  <= fpr_pkg::FUSE_SHIPPED;
      user_meta  <= fpr_pkg::USER_ERASED;
      user_sync  <= fpr_pkg::USER_ERASED;
      erase_meta <= 1'b0;
      erase_sync <= 1'b0;
    end else begin
      fuse_meta  <= fuse_array;
      fuse_sync  <= fuse_meta;
      user_meta  <= user_word0;
      user_sync  <= user_meta;
      erase_meta <= chip_erase;
      erase_sync <= erase_meta;
    end
  end

  // ==========================================================================
  // Latched fuse and user page state
  logic [31:0] fuse_word;
  logic [31:0] user_word;
  logic        load_pending;
  logic [1:0]  load_count;

  // Reload for three edges after reset release, so the last load sees a synchronised pin value.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_count <= fpr_pkg::LOAD_CYCLES;
    end else if (load_count != 2'h0) begin
      load_count <= load_count - 2'h1;
    end
  end

  // Loading stays open while the count runs.
  assign load_pending = (load_count != 2'h0);

  // Fuse word: picked up after reset, forced erased by chip erase.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fuse_word <= fpr_pkg::FUSE_SHIPPED;
    end else if (erase_sync) begin
      fuse_word <= fpr_pkg::FUSE_ERASED;
    end else if (load_pending) begin
      fuse_word <= fuse_sync;
    end
  end

  // User page word: captured only after reset, later edits wait for a reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      user_word <= fpr_pkg::USER_ERASED;
    end else if (load_pending) begin
      user_word <= user_sync;
    end
  end

  // ==========================================================================
  // Decoded configuration outputs
  logic [1:0] bod_en_code;
  assign bod_en_code = fuse_word[fpr_pkg::BOD_EN_LSB +: 2];

  // Brown-out detector decode.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bod_cfg <= '0;
    end else begin
      bod_cfg.enable       <= (bod_en_code == fpr_pkg::BOD_EN_RESET) ||
                              (bod_en_code == fpr_pkg::BOD_EN_NORST);
      bod_cfg.reset_enable <= (bod_en_code == fpr_pkg::BOD_EN_RESET);
      bod_cfg.hysteresis   <= fuse_word[fpr_pkg::BOD_HYST_POS];
      bod_cfg.level        <= fuse_word[fpr_pkg::BOD_LEVEL_LSB +: 6];
      bod_cfg.level_inert  <= (fuse_word[fpr_pkg::BOD_LEVEL_LSB +: 6] == 6'h00);
    end
  end

  // Protection decode.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prot_cfg <= '0;
    end else begin
      prot_cfg.user_page_guard  <= fuse_word[fpr_pkg::USER_GUARD_POS];
      prot_cfg.boot_guard_field <= fuse_word[fpr_pkg::BOOT_GUARD_LSB +: 3];
      prot_cfg.boot_guard_off   <= &fuse_word[fpr_pkg::BOOT_GUARD_LSB +: 3];
      prot_cfg.fetch_unlocked   <= fuse_word[fpr_pkg::FETCH_LOCK_POS];
      prot_cfg.region_lock      <= ~fuse_word[fpr_pkg::REGION_LOCK_LSB +: 16];
      prot_cfg.all_regions_open <= &fuse_word[fpr_pkg::REGION_LOCK_LSB +: 16];
    end
  end

  // Watchdog autostart is active when the user page bit is programmed to zero.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_autostart <= 1'b0;
    end else begin
      watchdog_autostart <= ~user_word[fpr_pkg::WDT_AUTO_POS];
    end
  end

  // ==========================================================================
  // Register read path
  logic [31:0] geometry_word;
  logic [31:0] revision_word;
  logic [31:0] next_rdata;

  // Geometry and revision words; reserved bits read as zero.
  always_comb begin
    geometry_word = '0;
    geometry_word[fpr_pkg::PAGE_SIZE_LSB +: 3]  = PAGE_SIZE_CODE;
    geometry_word[fpr_pkg::FLASH_SIZE_LSB +: 4] = FLASH_SIZE_CODE;
    revision_word = '0;
    revision_word[11:0]                       = REVISION;
    revision_word[fpr_pkg::VARIANT_LSB +: 4]  = VARIANT;
  end

  // Address decode; unmapped offsets read zero.
  always_comb begin
    case (addr)
      fpr_pkg::OFS_GEOMETRY:   next_rdata = geometry_word;
      fpr_pkg::OFS_REVISION:   next_rdata = revision_word;
      fpr_pkg::OFS_FUSE_UPPER: next_rdata = fpr_pkg::UPPER_UNUSED;
      fpr_pkg::OFS_FUSE_LOWER: next_rdata = fuse_word;
      default:                 next_rdata = 32'h00000000;
    endcase
  end

  // Read data stands for the one cycle after a read strobe, zero otherwise.
  // Write strobe and write data are deliberately not used by any register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 32'h00000000;
    end
  end

  logic unused_wr;
  assign unused_wr = wr_en ^ (^wdata);

endmodule

// ---- test/fpr_readout_monitor.sv ----
// Checker for the flash parameter and fuse readout register bank.
`timescale 1ns/1ps

// ==========================================================================
// Port-level assertions
module fpr_readout_monitor #(
  parameter logic [2:0]  PAGE_SIZE_CODE  = 3'h0,
  parameter logic [3:0]  FLASH_SIZE_CODE = 4'h0,
  parameter logic [11:0] REVISION        = 12'h000,
  parameter logic [3:0]  VARIANT         = 4'h0
) (
  // Clock, reset and register port.
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic [7:0]             addr,
  input wire logic [31:0]            wdata,
  input wire logic                   wr_en,
  input wire logic                   rd_en,
  input wire logic [31:0]            rdata,
  // Stored contents, erase and decoded outputs.
  input wire logic [31:0]            fuse_array,
  input wire logic [31:0]            user_word0,
  input wire logic                   chip_erase,
  input wire fpr_pkg::fpr_bod_cfg_s  bod_cfg,
  input wire fpr_pkg::fpr_prot_cfg_s prot_cfg,
  input wire logic                   watchdog_autostart
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Erase held long enough for the word, and then for the decoders.
  sequence s_erase_word;
    chip_erase [*5];
  endsequence
  sequence s_erase_decoded;
    chip_erase [*7];
  endsequence

  a_geometry_read: assert property (rd_en && addr == 8'h0C |=>
    rdata == {21'h0, PAGE_SIZE_CODE, 4'h0, FLASH_SIZE_CODE}) else $error("geometry read wrong");
  a_revision_read: assert property (rd_en && addr == 8'h10 |=>
    rdata == {12'h0, VARIANT, 4'h0, REVISION}) else $error("revision read wrong");
  a_upper_zero: assert property (rd_en && addr == 8'h14 |=> rdata == 32'h0) else $error("upper word not zero");
  a_idle_quiet: assert property (!rd_en |=> rdata == 32'h0) else $error("data without read");
  a_erase_ones: assert property (s_erase_word ##0 (rd_en && addr == 8'h18) |=>
    rdata == 32'hFFFFFFFF) else $error("erased word wrong");
  a_erase_decode: assert property (s_erase_decoded |-> bod_cfg.level == 6'h3F) else $error("erase not decoded");
  a_bod_reset: assert property (bod_cfg.reset_enable |-> bod_cfg.enable) else $error("reset without detector");
  a_level_inert: assert property (bod_cfg.hysteresis |->
    bod_cfg.level_inert == (bod_cfg.level == 6'h00)) else $error("inert level wrong");
  a_boot_off: assert property (prot_cfg.boot_guard_off == (prot_cfg.boot_guard_field == 3'h7))
    else $error("boot guard decode wrong");
  a_regions_open: assert property (prot_cfg.all_regions_open |-> prot_cfg.region_lock == 16'h0)
    else $error("open with locked region");
endmodule

bind fpr_readout fpr_readout_monitor #(.PAGE_SIZE_CODE(PAGE_SIZE_CODE), .FLASH_SIZE_CODE(FLASH_SIZE_CODE),
  .REVISION(REVISION), .VARIANT(VARIANT)) u_mon (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .fuse_array(fuse_array), .user_word0(user_word0),
  .chip_erase(chip_erase), .bod_cfg(bod_cfg), .prot_cfg(prot_cfg), .watchdog_autostart(watchdog_autostart));

// ---- test/test_flash_param_fuse_readout.sv ----
// Self-checking testbench for the flash parameter and fuse readout bank.
`timescale 1ns/1ps

// ==========================================================================
// Bench
module test_flash_param_fuse_readout;
  typedef struct packed { logic [7:0] a; logic [31:0] v; } fpr_row_s;
  localparam logic [11:0] REV = 12'h05A; // Arbitrary value.
  localparam logic [3:0]  VAR = 4'h3;    // Arbitrary value.
  logic                   clock, rst_n, wr_en, rd_en, chip_erase;
  logic [7:0]             addr;
  logic [31:0]            wdata, rdata, fuse_array, user_word0;
  fpr_pkg::fpr_bod_cfg_s  bod_cfg;
  fpr_pkg::fpr_prot_cfg_s prot_cfg;
  logic                   watchdog_autostart;
  int                     fail_count = 0, check_count = 0, cycles = 0;
  fpr_row_s               rows [5];

  fpr_readout #(.REVISION(REV), .VARIANT(VAR)) dut_u (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .fuse_array(fuse_array),
    .user_word0(user_word0), .chip_erase(chip_erase), .bod_cfg(bod_cfg), .prot_cfg(prot_cfg),
    .watchdog_autostart(watchdog_autostart));

  // Clock generator and run-length guard.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      final_report();
    end
  end

  // Comparison, bus cycles and reset.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) {wr_en, addr, wdata} <= {1'b1, a, d};
    @(posedge clock) wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock) {rd_en, addr} <= {1'b1, a};
    @(posedge clock) rd_en <= 1'b0;
    @(negedge clock) d = rdata;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Main sequence: table of reads after ignored writes, then decode, erase and reset cases.
  initial begin
    logic [31:0] d;
    {rst_n, wr_en, rd_en, chip_erase, addr, wdata} = '0;
    fuse_array = 32'hE07FFFFF;
    user_word0 = 32'hFFFFFFFF;
    rows = '{'{8'h0C, {21'h0, fpr_pkg::PAGE_CODE_DEF, 4'h0, fpr_pkg::FLASH_CODE_DEF}},
             '{8'h10, {12'h0, VAR, 4'h0, REV}}, '{8'h14, 32'h0},
             '{8'h18, 32'hE07FFFFF}, '{8'h20, 32'h0}};
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, ~rows[i].v);
      rd(rows[i].a, d);
      chk(d, rows[i].v);
    end
    chk(bod_cfg.enable, 1'b0);
    chk(bod_cfg.hysteresis, 1'b1);
    chk(bod_cfg.level_inert, 1'b1);
    chk({prot_cfg.boot_guard_off, prot_cfg.fetch_unlocked, prot_cfg.all_regions_open}, 3'h7);
    chk(watchdog_autostart, 1'b0);
    @(posedge clock) chip_erase <= 1'b1;
    repeat (6) @(posedge clock);
    rd(8'h18, d);
    chk(d, 32'hFFFFFFFF);
    chk({bod_cfg.level, bod_cfg.level_inert}, {6'h3F, 1'b0});
    chip_erase <= 1'b0;
    fuse_array <= 32'h4A855AAA;
    user_word0 <= 32'hFFFFFFFE;
    do_reset();
    rd(8'h18, d);
    chk(d, 32'h4A855AAA);
    chk({bod_cfg.enable, bod_cfg.reset_enable}, 2'h3);
    chk(watchdog_autostart, 1'b1);
    user_word0 <= 32'hFFFFFFFF;
    repeat (6) @(posedge clock);
    chk(watchdog_autostart, 1'b1);
    final_report();
  end
endmodule
